/* hdl/i2c_rdptr_defines.svh */
/*
  Constants of the two-wire slave read pointer block: widths, counts and reset values.
  Assumes inclusion by bare name from the package and the design file.
*/
`ifndef I2C_RDPTR_DEFINES_SVH
`define I2C_RDPTR_DEFINES_SVH

// ----------------------------------------
// Widths and counts
// ----------------------------------------
`define PTR_W          8
`define BYTE_W         8
`define SLV_ADDR_W     7
`define BIT_CNT_W      4
`define BITS_PER_BYTE  4'h8
`define FIFO_DEPTH     4
`define SYNC_STAGES    2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PTR_RST        8'h00
`define SLV_ADDR_DEF   7'h2A

`endif

/* hdl/i2c_rdptr_pkg.sv */
/*
  Types shared by the two-wire slave read pointer block.
  Assumes the defines header is on the include path.
*/
`include "i2c_rdptr_defines.svh"

package i2c_rdptr_pkg;

  // One queued write: target location and its data
  typedef struct packed {
    logic [`PTR_W-1:0]  addr;
    logic [`BYTE_W-1:0] data;
  } wr_entry_t;

  // Serial sequencer states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE   = 6'h01,
    ST_DEVADR = 6'h02,
    ST_ACK    = 6'h04,
    ST_WRBYTE = 6'h08,
    ST_TX     = 6'h10,
    ST_RXACK  = 6'h20
  } slv_state_t;

endpackage

/* hdl/i2c_slave_read_pointer.sv */
/*
  Two-wire bus slave with an 8-bit byte pointer, a write queue and a 256-byte store.
  Assumes the serial clock and data pins are asynchronous to i_core_clk and at least
  eight core clocks per serial clock period; the data pin is open drain, resolved outside.
*/
`include "i2c_rdptr_defines.svh"

// ----------------------------------------
// Write queue: flop storage, power-of-two depth
// ----------------------------------------
module wr_queue_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = `FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             i_core_clk,
  input  wire logic             i_sys_rst,
  // Fill side
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // Drain side
  output logic                  o_out_valid,
  output logic      [WIDTH-1:0] o_out_data,
  input  wire logic             i_out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store_r [DEPTH];   // Entry storage
  logic [AW-1:0]    wr_r;              // Fill index
  logic [AW-1:0]    rd_r;              // Drain index
  logic [AW:0]      cnt_r;             // Occupancy
  logic             push;
  logic             pop;

  assign o_in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_r != '0);
  assign o_out_data  = store_r[rd_r];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  // Storage write; indices wrap naturally since depth is a power of two
  always_ff @(posedge i_core_clk)
  begin
    if (push)
    begin
      store_r[wr_r] <= i_in_data;
    end
  end

  // Index and occupancy bookkeeping
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_r <= wr_r + 1'b1;
      end
      if (pop)
      begin
        rd_r <= rd_r + 1'b1;
      end
      if (push && !pop)
      begin
        cnt_r <= cnt_r + 1'b1;
      end
      else if (pop && !push)
      begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule

module i2c_slave_read_pointer #(
  parameter logic [`SLV_ADDR_W-1:0] SLAVE_SELECT_ADDRESS = `SLV_ADDR_DEF  // Arbitrary value
) (
  // Clock and reset
  input  wire logic              i_core_clk,
  input  wire logic              i_sys_rst,
  // Serial pins
  input  wire logic              i_scl,
  input  wire logic              i_sda,
  output logic                   o_sda_out,
  output logic                   o_sda_oe_n,
  // Status
  output logic [`PTR_W-1:0]      o_byte_pointer_value
);
  import i2c_rdptr_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [1:0]               sync1_r;        // First sync stage {sda, scl}
  logic [1:0]               sync2_r;        // Second sync stage
  logic                     scl_d_r;        // Delayed clean clock
  logic                     sda_d_r;        // Delayed clean data
  logic                     scl_rise;
  logic                     scl_fall;
  logic                     start_ev;
  logic                     stop_ev;
  slv_state_t               state_r;        // Sequencer state
  logic [`BIT_CNT_W-1:0]    bit_cnt_r;      // Bits seen in this byte
  logic [`BYTE_W-1:0]       rx_r;           // Receive shifter
  logic [`BYTE_W-1:0]       tx_r;           // Transmit shifter
  logic                     rw_r;           // Direction of this frame
  logic                     addr_phase_r;   // Next write byte is the pointer
  logic                     ack_ok_r;       // Master acknowledged last byte
  logic                     sda_oe_n_r;
  logic                     sda_out_r;
  logic [`PTR_W-1:0]        ptr_r;          // byte_pointer_value
  logic [`BYTE_W-1:0]       mem_r [1 << `PTR_W];
  logic                     byte_done;
  logic                     adr_hit;
  logic                     wr_end;
  logic                     ptr_load;
  logic                     wr_take;
  logic                     tx_load;
  logic                     q_in_ready;
  logic                     q_out_valid;
  logic                     drain_rdy;
  wr_entry_t                q_in;
  wr_entry_t                q_out;

  // Byte boundary in a given state, seen at the falling serial clock
  function automatic logic byte_end(input slv_state_t st, input slv_state_t want,
                                    input logic fall, input logic done);
    byte_end = (st == want) && fall && done;
  endfunction

  // ----------------------------------------
  // Pin synchronisers and bus events
  // ----------------------------------------
  // Two flops per pin; only the second stage feeds logic
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_sync
      always_ff @(posedge i_core_clk)
      begin
        if (i_sys_rst)
        begin
          sync1_r[g] <= 1'b1;
          sync2_r[g] <= 1'b1;
        end
        else
        begin
          sync1_r[g] <= (g == 0) ? i_scl : i_sda;
          sync2_r[g] <= sync1_r[g];
        end
      end
    end
  endgenerate

  // Edge history of the cleaned pins
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end
    else
    begin
      scl_d_r <= sync2_r[0];
      sda_d_r <= sync2_r[1];
    end
  end

  assign scl_rise  = sync2_r[0] && !scl_d_r;
  assign scl_fall  = !sync2_r[0] && scl_d_r;
  assign start_ev  = sync2_r[0] && scl_d_r && sda_d_r && !sync2_r[1];
  assign stop_ev   = sync2_r[0] && scl_d_r && !sda_d_r && sync2_r[1];
  assign byte_done = (bit_cnt_r == `BITS_PER_BYTE);

  // ----------------------------------------
  // Decisions at byte boundaries
  // ----------------------------------------
  // Only our address is answered; the block never drives the clock
  assign adr_hit  = byte_end(state_r, ST_DEVADR, scl_fall, byte_done)
                    && (rx_r[7:1] == SLAVE_SELECT_ADDRESS);
  assign wr_end   = byte_end(state_r, ST_WRBYTE, scl_fall, byte_done);
  assign ptr_load = wr_end && addr_phase_r;
  // A full queue refuses the byte with a NACK rather than losing it
  assign wr_take  = wr_end && !addr_phase_r && q_in_ready;
  assign tx_load  = scl_fall && (((state_r == ST_ACK) && rw_r)
                    || ((state_r == ST_RXACK) && ack_ok_r));
  assign q_in     = '{addr: ptr_r, data: rx_r};
  // Hold queued writes back while a read is being shifted so the store stays still
  assign drain_rdy = !((state_r == ST_TX) || (state_r == ST_RXACK));

  // ----------------------------------------
  // Serial sequencer
  // ----------------------------------------
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      state_r      <= ST_IDLE;
      bit_cnt_r    <= '0;
      rx_r         <= '0;
      rw_r         <= 1'b0;
      addr_phase_r <= 1'b0;
      ack_ok_r     <= 1'b0;
    end
    else if (start_ev)
    begin
      // Plain or repeated START: address byte follows
      state_r   <= ST_DEVADR;
      bit_cnt_r <= '0;
    end
    else if (stop_ev)
    begin
      state_r <= ST_IDLE;
    end
    else
    begin
      case (state_r)
        ST_DEVADR, ST_WRBYTE:
        begin
          if (scl_rise)
          begin
            rx_r      <= {rx_r[6:0], sync2_r[1]};
            bit_cnt_r <= bit_cnt_r + 1'b1;
          end
          else if (scl_fall && byte_done)
          begin
            bit_cnt_r <= '0;
            if (state_r == ST_DEVADR)
            begin
              state_r      <= adr_hit ? ST_ACK : ST_IDLE;
              rw_r         <= rx_r[0];
              addr_phase_r <= 1'b1;
            end
            else
            begin
              state_r <= (ptr_load || wr_take) ? ST_ACK : ST_IDLE;
              if (ptr_load)
              begin
                addr_phase_r <= 1'b0;
              end
            end
          end
        end
        ST_ACK:
        begin
          if (scl_fall)
          begin
            state_r   <= rw_r ? ST_TX : ST_WRBYTE;
            bit_cnt_r <= '0;
          end
        end
        ST_TX:
        begin
          if (scl_rise)
          begin
            bit_cnt_r <= bit_cnt_r + 1'b1;
          end
          else if (scl_fall && byte_done)
          begin
            state_r   <= ST_RXACK;
            bit_cnt_r <= '0;
          end
        end
        ST_RXACK:
        begin
          if (scl_rise)
          begin
            ack_ok_r <= !sync2_r[1];
          end
          else if (scl_fall)
          begin
            // NACK: wait idle for the STOP
            state_r <= ack_ok_r ? ST_TX : ST_IDLE;
          end
        end
        default:
        begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Byte pointer
  // ----------------------------------------
  // Pointer ends one past the last access; the 8-bit add wraps FFh to 00h
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      ptr_r <= `PTR_RST;
    end
    else if (ptr_load)
    begin
      ptr_r <= rx_r;
    end
    else if (wr_take || tx_load)
    begin
      ptr_r <= ptr_r + 1'b1;
    end
  end

  // ----------------------------------------
  // Data line drive
  // ----------------------------------------
  // Pulled low only after a falling serial clock, so data is stable while it is high; START or STOP releases it
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      sda_oe_n_r <= 1'b1;
      sda_out_r  <= 1'b0;
      tx_r       <= '0;
    end
    else if (start_ev || stop_ev)
    begin
      sda_oe_n_r <= 1'b1;
    end
    else if (adr_hit || ptr_load || wr_take)
    begin
      sda_oe_n_r <= 1'b0;
    end
    else if (tx_load)
    begin
      tx_r       <= mem_r[ptr_r];
      sda_oe_n_r <= mem_r[ptr_r][7];
    end
    else if ((state_r == ST_TX) && scl_fall && !byte_done)
    begin
      tx_r       <= {tx_r[6:0], 1'b0};
      sda_oe_n_r <= tx_r[6];
    end
    else if (scl_fall)
    begin
      // Release for master acknowledge and after our own
      sda_oe_n_r <= 1'b1;
    end
  end

  // ----------------------------------------
  // Write queue and store
  // ----------------------------------------
  wr_queue_fifo #(
    .WIDTH ($bits(wr_entry_t)),
    .DEPTH (`FIFO_DEPTH)
  ) u_wr_queue (
    .i_core_clk  (i_core_clk),
    .i_sys_rst   (i_sys_rst),
    .i_in_valid  (wr_end && !addr_phase_r),
    .i_in_data   (q_in),
    .o_in_ready  (q_in_ready),
    .o_out_valid (q_out_valid),
    .o_out_data  (q_out),
    .i_out_ready (drain_rdy)
  );

  // Store is data only, so it carries no reset
  always_ff @(posedge i_core_clk)
  begin
    if (q_out_valid && drain_rdy)
    begin
      mem_r[q_out.addr] <= q_out.data;
    end
  end

  assign o_sda_out            = sda_out_r;
  assign o_sda_oe_n           = sda_oe_n_r;
  assign o_byte_pointer_value = ptr_r;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_sys_rst);

  sequence s_read_ack_end;
    (state_r == ST_ACK) && rw_r && scl_fall;
  endsequence
  sequence s_master_ack_end;
    (state_r == ST_RXACK) && ack_ok_r && scl_fall;
  endsequence

  property p_first_byte;
    s_read_ack_end |=> (tx_r == mem_r[$past(ptr_r)]) && (state_r == ST_TX);
  endproperty
  a_first_byte: assert property (p_first_byte) else $error("read byte not from pointer");

  property p_next_byte;
    s_master_ack_end |=> (ptr_r == $past(ptr_r) + 8'h01) && (tx_r == mem_r[$past(ptr_r)]);
  endproperty
  a_next_byte: assert property (p_next_byte) else $error("ack did not fetch next byte");

  property p_wrap;
    (tx_load && (ptr_r == 8'hFF)) |=> (ptr_r == 8'h00);
  endproperty
  a_wrap: assert property (p_wrap) else $error("pointer did not wrap");

  property p_stop_release;
    stop_ev |=> sda_oe_n_r [*2];
  endproperty
  a_stop_release: assert property (p_stop_release) else $error("data held after stop");

  property p_ack_low;
    (adr_hit || ptr_load || wr_take) |=> !sda_oe_n_r throughout (state_r == ST_ACK) [*1];
  endproperty
  a_ack_low: assert property (p_ack_low) else $error("no acknowledge drive");

  property p_foreign_addr;
    (byte_end(state_r, ST_DEVADR, scl_fall, byte_done) && (rx_r[7:1] != SLAVE_SELECT_ADDRESS))
      |=> (state_r == ST_IDLE) && sda_oe_n_r;
  endproperty
  a_foreign_addr: assert property (p_foreign_addr) else $error("answered foreign address");

  // Pointer takes the received byte and the byte is acknowledged
  property p_ptr_load;
    ptr_load |=> (ptr_r == $past(rx_r)) && (state_r == ST_ACK);
  endproperty
  a_ptr_load: assert property (p_ptr_load) else $error("pointer not loaded");

  // An empty queue must stay empty after the pointer byte: nothing is queued for the store
  property p_addr_no_store;
    (ptr_load && !q_out_valid) |=> !q_out_valid;
  endproperty
  a_addr_no_store: assert property (p_addr_no_store) else $error("address byte stored");

  property p_wr_advance;
    wr_take |=> (ptr_r == $past(ptr_r) + 8'h01) && q_out_valid;
  endproperty
  a_wr_advance: assert property (p_wr_advance) else $error("write did not advance");
endmodule

/* sim/i2c_master_model.sv */
/*
  Behavioural two-wire bus master that stands opposite the slave in the bench.
  Assumes an open-drain data line with a pull-up, resolved in the bench, and a core
  clock whose falling edge paces every pin change; one bit is 8 core clocks.
*/
module i2c_master_model (
  // Pacing clock and resolved data line
  input  wire logic i_core_clk,
  input  wire logic i_sda,
  // Master pins
  output logic      o_scl,
  output logic      o_sda_low
);
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------
  // Pin timing helpers
  // ----------------------------------------
  initial
  begin
    o_scl     = 1'b1;  // Serial clock stands still high outside frames
    o_sda_low = 1'b0;  // Line released, pull-up makes it high
  end

  task automatic tick(input int n);
    repeat (n) @(negedge i_core_clk);
  endtask

  // One bit: low 5 clocks, high 3, sampled mid-high so a slave answer after the fall has settled
  task automatic bit_cyc(input logic drv_low, output logic seen);
    o_scl = 1'b0;
    tick(1);
    o_sda_low = drv_low;
    tick(4);
    o_scl = 1'b1;
    tick(2);
    seen = i_sda;
    tick(1);
  endtask

  // ----------------------------------------
  // Frame conditions
  // ----------------------------------------
  task automatic start_c;
    o_sda_low = 1'b1;  // Data falls while clock high
    tick(4);
  endtask

  // Repeated start after an acknowledged pointer byte, no stop between
  task automatic rstart;
    o_scl = 1'b0;
    tick(1);
    o_sda_low = 1'b0;
    tick(4);
    o_scl = 1'b1;
    tick(3);
    o_sda_low = 1'b1;
    tick(3);
  endtask

  task automatic stop_c;
    o_scl = 1'b0;
    tick(1);
    o_sda_low = 1'b1;
    tick(4);
    o_scl = 1'b1;
    tick(4);
    o_sda_low = 1'b0;  // Data rises while clock high
    tick(6);
  endtask

  // ----------------------------------------
  // Byte transfers, most significant bit first
  // ----------------------------------------
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_cyc(~b[i], s);
    bit_cyc(1'b0, s);  // Release for the slave acknowledge
    ack = ~s;
  endtask

  // Acknowledge asks for the next byte, no acknowledge ends the read
  task automatic recv_byte(input logic give_ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_cyc(1'b0, s);
      b[i] = s;
    end
    bit_cyc(give_ack, s);
  endtask
endmodule

/* sim/i2c_slave_read_pointer_tb.sv */
/*
  Self-checking bench of the slave read pointer block: a master model drives frames,
  a byte-store model with a pointer predicts acknowledges, read data and pointer.
  Assumes the design store is undefined until written, so only written bytes are read.
*/
module i2c_slave_read_pointer_tb;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [6:0] SLV = 7'h2A;  // Arbitrary slave address

  logic       i_core_clk = 1'b0;   // Core clock, 100 ns
  logic       i_sys_rst  = 1'b1;   // Synchronous reset
  logic       scl;                 // Master serial clock
  logic       m_low;               // Master pulls data low
  logic       sda_wire;            // Resolved open-drain data line
  logic       sda_out;             // Slave drive value
  logic       sda_oe_n;            // Slave enable, low pulls the line
  logic [7:0] ptr_o;               // Slave pointer
  logic [7:0] mem [256];           // Predicted store
  int         ptr;                 // Predicted pointer
  int         seed = 43;           // Random seed
  int         bad_count = 0;       // Mismatches
  int         samples_checked = 0; // Comparisons
  int         cycles = 0;          // Timeout counter

  // Pull-up wins unless somebody pulls low
  assign sda_wire = !(m_low || (!sda_oe_n && !sda_out));

  always #50 i_core_clk = ~i_core_clk;

  i2c_slave_read_pointer #(.SLAVE_SELECT_ADDRESS(SLV)) i2c_slave_read_pointer_i (
    .i_core_clk           (i_core_clk),
    .i_sys_rst            (i_sys_rst),
    .i_scl                (scl),
    .i_sda                (sda_wire),
    .o_sda_out            (sda_out),
    .o_sda_oe_n           (sda_oe_n),
    .o_byte_pointer_value (ptr_o)
  );

  i2c_master_model i2c_master_model_i (
    .i_core_clk (i_core_clk),
    .i_sda      (sda_wire),
    .o_scl      (scl),
    .o_sda_low  (m_low)
  );

  // ----------------------------------------
  // Reporting
  // ----------------------------------------
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk_ack(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic chk_val(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Hang guard: some 400 bytes' worth of bus time
  always @(posedge i_core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      bad_count++;
      $display("[ERR] run time expected under 30000 cycles seen more");
      close_out();
    end
  end

  // ----------------------------------------
  // Frames
  // ----------------------------------------
  // Pointer byte, then n data bytes; ends with a stop or a repeated start
  task automatic wr_frame(input logic [7:0] a, input int n, input bit keep);
    logic       ack;
    logic [7:0] d;
    i2c_master_model_i.start_c();
    i2c_master_model_i.send_byte({SLV, 1'b0}, ack);
    chk_ack("write address ack", 1'b1, ack);
    i2c_master_model_i.send_byte(a, ack);
    chk_ack("pointer byte ack", 1'b1, ack);
    ptr = a;
    for (int i = 0; i < n; i++)
    begin
      d = 8'($random(seed));
      i2c_master_model_i.send_byte(d, ack);
      chk_ack("data byte ack", 1'b1, ack);
      mem[ptr] = d;
      ptr = (ptr + 1) & 255;
    end
    if (keep)
      i2c_master_model_i.rstart();
    else
    begin
      i2c_master_model_i.stop_c();
      chk_val("pointer after write", 8'(ptr), ptr_o);
    end
  endtask

  // Read n bytes at the pointer, acknowledging all but the last
  task automatic rd_frame(input bit fresh, input int n);
    logic       ack;
    logic [7:0] d;
    if (fresh)
      i2c_master_model_i.start_c();
    i2c_master_model_i.send_byte({SLV, 1'b1}, ack);
    chk_ack("read address ack", 1'b1, ack);
    for (int i = 0; i < n; i++)
    begin
      i2c_master_model_i.recv_byte(i != n - 1, d);
      chk_val("read byte", mem[ptr], d);
      ptr = (ptr + 1) & 255;
    end
    i2c_master_model_i.stop_c();
    chk_ack("data released after stop", 1'b1, sda_oe_n);
    chk_val("pointer after read", 8'(ptr), ptr_o);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    logic ack;
    int   a;
    int   n;
    repeat (6) @(negedge i_core_clk);
    i_sys_rst = 1'b0;
    repeat (4) @(negedge i_core_clk);
    chk_val("pointer after reset", 8'h00, ptr_o);
    chk_ack("data released after reset", 1'b1, sda_oe_n);
    $display("test reset done");
    wr_frame(8'hFE, 4, 1'b0);
    $display("test multi-byte write across the top done");
    wr_frame(8'hFE, 0, 1'b1);
    rd_frame(1'b0, 3);
    $display("test random sequential read done");
    rd_frame(1'b1, 1);
    $display("test current-address read done");
    i2c_master_model_i.start_c();
    i2c_master_model_i.send_byte({SLV ^ 7'h01, 1'b0}, ack);
    chk_ack("foreign address ack", 1'b0, ack);
    i2c_master_model_i.stop_c();
    chk_val("pointer after foreign frame", 8'(ptr), ptr_o);
    $display("test foreign address done");
    for (int k = 0; k < 5; k++)
    begin
      a = $random(seed) & 255;
      n = 1 + ($random(seed) & 3);
      wr_frame(8'(a), n, 1'b0);
      wr_frame(8'(a), 0, 1'b1);
      rd_frame(1'b0, n);
    end
    $display("test random write and read back done");
    close_out();
  end
endmodule
